// ### rtl/apd_pkg.sv
// Package for the channel post-processing block: register map, field
// positions, pattern codes, bus carriers and datapath constants.
// Assumes 14-bit twos-complement samples and an AXI4-Lite register bus.
package apd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTL_GAIN = 6'h03;
  localparam logic [5:0] IDX_CTL_PAT  = 6'h04;
  localparam logic [5:0] IDX_CH4_GO   = 6'h13;
  localparam logic [5:0] IDX_CH4_COPY = 6'h14;
  localparam logic [5:0] IDX_LANE_HP  = 6'h15;
  localparam int         NREG         = 5;
  localparam int         RI_CTLG      = 0;
  localparam int         RI_CTLP      = 1;
  localparam int         RI_GO        = 2;
  localparam int         RI_CP        = 3;
  localparam int         RI_LH        = 4;
  localparam logic [NREG-1:0][5:0] REG_IDX = {IDX_LANE_HP, IDX_CH4_COPY, IDX_CH4_GO, IDX_CTL_PAT, IDX_CTL_GAIN};
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Field positions
  localparam int GAIN_EN_BIT = 12;
  localparam int OFS_EN_BIT  = 8;
  localparam int PATSEL_BIT  = 8;
  localparam int GAIN_MSB    = 15;
  localparam int GAIN_LSB    = 11;
  localparam int OFS_MSB     = 9;
  localparam int OFS_LSB     = 0;
  localparam int PRBS1_BIT   = 15;
  localparam int P1_MSB      = 11;
  localparam int P1_LSB      = 9;
  localparam int P2_MSB      = 8;
  localparam int P2_LSB      = 6;
  localparam int ROUND_BIT   = 5;
  localparam int K_MSB       = 4;
  localparam int K_LSB       = 1;
  localparam int HPEN_BIT    = 0;

  // Lane pattern codes in their encoded order
  typedef enum logic [2:0] {
    PAT_NORMAL, PAT_SYNC, PAT_ALT, PAT_CUSTOM, PAT_ONES, PAT_TOGGLE, PAT_ZEROS, PAT_RAMP
  } apd_pat_t;

  // Datapath constants
  localparam int                 GAIN_FRAC = 12;
  localparam int                 HP_FRAC   = 8;
  localparam logic signed [31:0] HP_HALF   = 32'sh0000_0080;
  localparam logic signed [31:0] SAT_HI    = 32'sh0000_1fff;
  localparam logic signed [31:0] SAT_LO    = 32'shffff_e000;
  localparam logic [13:0]        W_MAX     = 14'h1fff;
  localparam logic [13:0]        W_MIN     = 14'h2000;
  localparam logic [13:0]        W_ONES    = 14'h3fff;
  localparam logic [13:0]        W_ZEROS   = 14'h0000;
  localparam logic [13:0]        W_ALT     = 14'h1555;
  localparam logic [13:0]        W_ALT_N   = 14'h2aaa;
  localparam logic [13:0]        W_SYNC    = 14'h3f80;
  localparam logic [13:0]        RAMP_STEP = 14'h0001;
  localparam logic [15:0]        PRBS_SEED = 16'hace1;
  localparam logic [15:0]        PRBS_TAPS = 16'hb400;

  // Gain in steps of 0.2 dB, unsigned Q4.12, index 31 first
  localparam logic [31:0][15:0] GAIN_TAB = {
    16'h20ab, 16'h1fed, 16'h1f33, 16'h1e7d, 16'h1dcb, 16'h1d1e, 16'h1c74, 16'h1bce,
    16'h1b2c, 16'h1a8e, 16'h19f3, 16'h195c, 16'h18c8, 16'h1838, 16'h17ab, 16'h1721,
    16'h169a, 16'h1616, 16'h1595, 16'h1518, 16'h149d, 16'h1425, 16'h13af, 16'h133c,
    16'h12cc, 16'h125f, 16'h11f4, 16'h118b, 16'h1125, 16'h10c1, 16'h105f, 16'h1000};

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [3:0][13:0] apd_lanes_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } apd_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } apd_axi_rsp_t;

endpackage : apd_pkg

// ### rtl/apd_postproc.sv
// Channel 1-4 post-processing: channel 4 gain and offset, shared high-pass
// filter, lane pattern and PRBS override, AXI4-Lite register slave.
// Assumes one 20 MHz clock and samples presented with a one-cycle valid.
//
// Contract
// - Gain enable scales channel 4 by N*0.2dB
// - Offset enable adds signed 10-bit offset
// - Pattern select plus bit gives lane PRBS
// - Pattern select drives lanes 1,2 coded patterns
// - Code values map to eight lane patterns
// - Rounding bit picks round or truncate
// - High-pass filter with shift k
// - Bit 0 enables filter, bypass at reset
`timescale 1ns/1ns
`default_nettype none
module apd_postproc
  import apd_pkg::*;
#(
  parameter logic [13:0] CUSTOM_PATTERN = 14'h0000
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire apd_axi_req_t s_axi_i,
  output wire apd_axi_rsp_t s_axi_o,
  input  wire logic         sample_valid_i,
  input  wire apd_lanes_t   sample_i,
  output logic              lane_valid_o,
  output var  apd_lanes_t   lane_data_o
);

  typedef struct packed {
    logic [NREG-1:0][15:0] regs;
    logic                  aw_hold;
    logic                  w_hold;
    logic [5:0]            aw_idx;
    logic [15:0]           wdat;
    logic [1:0]            wbe;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [15:0]           rdat;
    apd_lanes_t            xprev;
    logic [3:0][31:0]      yacc;
    apd_lanes_t            lane;
    logic                  lvalid;
    logic [15:0]           prbs;
    logic [13:0]           ramp;
    logic                  tog;
  } apd_st_t;

  apd_st_t              st_ff;
  apd_st_t              nxt_st;
  logic                 rst_meta_ff;
  logic                 rst_sync_ff;
  logic                 aw_take;
  logic                 w_take;
  logic                 ar_take;
  logic [NREG-1:0]      wsel;
  logic [NREG-1:0]      rsel;
  logic [3:0][13:0]     trunc_c;
  logic [3:0][13:0]     round_c;

  // One-hot register decode, shared by the read and write paths
  function automatic logic [NREG-1:0] reg_dec(input logic [5:0] idx);
    reg_dec = '0;
    for (int j = 0; j < NREG; j++) begin
      reg_dec[j] = (idx == REG_IDX[j]);
    end
  endfunction : reg_dec

  // Clamp to the 14-bit signed range instead of wrapping
  function automatic logic [13:0] sat14(input logic signed [31:0] v);
    if (v > SAT_HI) begin
      sat14 = W_MAX;
    end else if (v < SAT_LO) begin
      sat14 = W_MIN;
    end else begin
      sat14 = v[13:0];
    end
  endfunction : sat14

  // Reset released through two flops so removal is clean
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Bus handshakes; new requests wait while a response is pending
  assign s_axi_o.awready = !st_ff.aw_hold && !st_ff.bvalid;
  assign s_axi_o.wready  = !st_ff.w_hold && !st_ff.bvalid;
  assign s_axi_o.arready = !st_ff.rvalid;
  assign s_axi_o.bvalid  = st_ff.bvalid;
  assign s_axi_o.bresp   = st_ff.bresp;
  assign s_axi_o.rvalid  = st_ff.rvalid;
  assign s_axi_o.rresp   = st_ff.rresp;
  assign s_axi_o.rdata   = {16'h0000, st_ff.rdat};
  assign aw_take         = s_axi_i.awvalid && s_axi_o.awready;
  assign w_take          = s_axi_i.wvalid && s_axi_o.wready;
  assign ar_take         = s_axi_i.arvalid && s_axi_o.arready;
  assign wsel            = reg_dec(st_ff.aw_idx);
  assign rsel            = reg_dec(s_axi_i.araddr[7:2]);
  assign lane_valid_o    = st_ff.lvalid;
  assign lane_data_o     = st_ff.lane;

  // Next state: register file, bus slave and the sample datapath
  always_comb begin
    logic signed [31:0] xe;
    logic signed [31:0] ge;
    logic signed [31:0] s;
    logic signed [31:0] y;
    logic [3:0][13:0]   xc;
    logic [3:0]         k;
    logic [2:0]         code;
    logic [13:0]        w;
    nxt_st  = st_ff;
    xe      = '0;
    ge      = '0;
    s       = '0;
    y       = '0;
    xc      = sample_i;
    k       = st_ff.regs[RI_LH][K_MSB:K_LSB];
    code    = PAT_NORMAL;
    w       = '0;
    trunc_c = '0;
    round_c = '0;

    // Write channel: capture address and data in either order
    if (aw_take) begin
      nxt_st.aw_hold = 1'b1;
      nxt_st.aw_idx  = s_axi_i.awaddr[7:2];
    end
    if (w_take) begin
      nxt_st.w_hold = 1'b1;
      nxt_st.wdat   = s_axi_i.wdata[15:0];
      nxt_st.wbe    = s_axi_i.wstrb[1:0];
    end
    // Reserved bits are stored as written; the host keeps them zero
    if (st_ff.aw_hold && st_ff.w_hold) begin
      nxt_st.aw_hold = 1'b0;
      nxt_st.w_hold  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = (wsel == '0) ? RESP_SLVERR : RESP_OKAY;
      for (int j = 0; j < NREG; j++) begin
        if (wsel[j] && st_ff.wbe[0]) nxt_st.regs[j][7:0] = st_ff.wdat[7:0];
        if (wsel[j] && st_ff.wbe[1]) nxt_st.regs[j][15:8] = st_ff.wdat[15:8];
      end
    end
    if (st_ff.bvalid && s_axi_i.bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Read channel: data registered one cycle after the address
    if (ar_take) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = (rsel == '0) ? RESP_SLVERR : RESP_OKAY;
      nxt_st.rdat   = '0;
      for (int j = 0; j < NREG; j++) begin
        if (rsel[j]) nxt_st.rdat = nxt_st.rdat | st_ff.regs[j];
      end
    end else if (st_ff.rvalid && s_axi_i.rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // Channel 4 gain then offset; only the primary offset copy is used
    if (st_ff.regs[RI_CTLG][GAIN_EN_BIT]) begin
      xe    = 32'(signed'(sample_i[3]));
      ge    = 32'(signed'({1'b0, GAIN_TAB[st_ff.regs[RI_GO][GAIN_MSB:GAIN_LSB]]}));
      xc[3] = sat14((xe * ge) >>> GAIN_FRAC);
    end
    if (st_ff.regs[RI_CTLG][OFS_EN_BIT]) begin
      xe    = 32'(signed'(xc[3]));
      ge    = 32'(signed'(st_ff.regs[RI_GO][OFS_MSB:OFS_LSB]));
      xc[3] = sat14(xe + ge);
    end

    // Shared high-pass: y = s*2^k/(2^k+1) taken as s - s/2^k + s/4^k
    for (int i = 0; i < 4; i++) begin
      s = (32'(signed'(xc[i])) <<< HP_FRAC) - (32'(signed'(st_ff.xprev[i])) <<< HP_FRAC)
          + signed'(st_ff.yacc[i]);
      y = s - (s >>> k) + (s >>> {k, 1'b0});
      trunc_c[i] = sat14(y >>> HP_FRAC);
      round_c[i] = sat14((y + HP_HALF) >>> HP_FRAC);
      if (sample_valid_i) begin
        nxt_st.xprev[i] = xc[i];
        // Accumulator cleared in bypass so enabling starts without a step
        nxt_st.yacc[i]  = st_ff.regs[RI_LH][HPEN_BIT] ? 32'(y) : '0;
      end
      if (st_ff.regs[RI_LH][HPEN_BIT]) begin
        w = st_ff.regs[RI_LH][ROUND_BIT] ? round_c[i] : trunc_c[i];
      end else begin
        w = xc[i];
      end

      // Lane override; PRBS has priority over the coded pattern
      if (i == 0) code = st_ff.regs[RI_LH][P1_MSB:P1_LSB];
      else if (i == 1) code = st_ff.regs[RI_LH][P2_MSB:P2_LSB];
      else code = PAT_NORMAL;
      if (st_ff.regs[RI_CTLP][PATSEL_BIT]) begin
        if (st_ff.regs[RI_LH][PRBS1_BIT-i]) begin
          w = st_ff.prbs[13:0];
        end else begin
          unique case (apd_pat_t'(code))
            PAT_NORMAL: w = w;
            PAT_SYNC:   w = W_SYNC;
            PAT_ALT:    w = W_ALT;
            PAT_CUSTOM: w = CUSTOM_PATTERN;
            PAT_ONES:   w = W_ONES;
            PAT_TOGGLE: w = st_ff.tog ? W_ALT_N : W_ALT;
            PAT_ZEROS:  w = W_ZEROS;
            PAT_RAMP:   w = st_ff.ramp;
          endcase
        end
      end
      if (sample_valid_i) nxt_st.lane[i] = w;
    end

    // Pattern generators advance once per sample
    nxt_st.lvalid = sample_valid_i;
    if (sample_valid_i) begin
      nxt_st.prbs = st_ff.prbs[0] ? ((st_ff.prbs >> 1) ^ PRBS_TAPS) : (st_ff.prbs >> 1);
      nxt_st.ramp = st_ff.ramp + RAMP_STEP;
      nxt_st.tog  = !st_ff.tog;
    end
  end

  // State register; all control fields zero so the filter is bypassed
  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff      <= '0;
      st_ff.prbs <= PRBS_SEED;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Shorthand for assertion conditions
  logic hp_on;
  logic pat_on;
  assign hp_on  = st_ff.regs[RI_LH][HPEN_BIT];
  assign pat_on = st_ff.regs[RI_CTLP][PATSEL_BIT];

  property p_gain;
    @(posedge clk_sys_i) disable iff (!rst_sync_ff)
      sample_valid_i && st_ff.regs[RI_CTLG][GAIN_EN_BIT] && !st_ff.regs[RI_CTLG][OFS_EN_BIT]
      && !hp_on && !pat_on && (st_ff.regs[RI_GO][GAIN_MSB:GAIN_LSB] != '0) && (sample_i[3] == 14'h03e8)
      |=> signed'(lane_data_o[3]) > signed'(14'h03e8);
  endproperty
  a_gain: assert property (p_gain) else $error("gain step did not raise channel 4");

  property p_offset;
    @(posedge clk_sys_i) disable iff (!rst_sync_ff)
      sample_valid_i && !st_ff.regs[RI_CTLG][GAIN_EN_BIT] && st_ff.regs[RI_CTLG][OFS_EN_BIT]
      && !hp_on && !pat_on && (sample_i[3] == '0)
      |=> lane_data_o[3] == 14'(signed'($past(st_ff.regs[RI_GO][OFS_MSB:OFS_LSB])));
  endproperty
  a_offset: assert property (p_offset) else $error("channel 4 offset not applied");

  property p_prbs;
    @(posedge clk_sys_i) disable iff (!rst_sync_ff)
      sample_valid_i && pat_on && st_ff.regs[RI_LH][PRBS1_BIT]
      |=> lane_valid_o && (lane_data_o[0] == $past(st_ff.prbs[13:0]));
  endproperty
  a_prbs: assert property (p_prbs) else $error("lane 1 not carrying PRBS");

  property p_lane2_zero;
    @(posedge clk_sys_i) disable iff (!rst_sync_ff)
      sample_valid_i && pat_on && !st_ff.regs[RI_LH][PRBS1_BIT-1]
      && (st_ff.regs[RI_LH][P2_MSB:P2_LSB] == PAT_ZEROS)
      |=> lane_data_o[1] == W_ZEROS;
  endproperty
  a_lane2_zero: assert property (p_lane2_zero) else $error("lane 2 zero pattern wrong");

  property p_lane1_toggle;
    @(posedge clk_sys_i) disable iff (!rst_sync_ff)
      sample_valid_i && pat_on && !st_ff.regs[RI_LH][PRBS1_BIT]
      && (st_ff.regs[RI_LH][P1_MSB:P1_LSB] == PAT_TOGGLE)
      ##1 !sample_valid_i && $stable(st_ff.regs) ##1 !sample_valid_i && $stable(st_ff.regs)
      ##1 sample_valid_i && $stable(st_ff.regs)
      |=> (lane_data_o[0] ^ $past(lane_data_o[0])) == W_ONES;
  endproperty
  a_lane1_toggle: assert property (p_lane1_toggle) else $error("lane 1 toggle not alternating");

  property p_round;
    @(posedge clk_sys_i) disable iff (!rst_sync_ff)
      sample_valid_i && hp_on && !pat_on && st_ff.regs[RI_LH][ROUND_BIT] && (trunc_c[2] != W_MAX)
      |=> (lane_data_o[2] == $past(trunc_c[2])) || (lane_data_o[2] == $past(trunc_c[2]) + RAMP_STEP);
  endproperty
  a_round: assert property (p_round) else $error("rounded output off by more than one");

  property p_hpf_dc;
    @(posedge clk_sys_i) disable iff (!rst_sync_ff)
      sample_valid_i && hp_on && !pat_on && (sample_i[2] == st_ff.xprev[2]) && (st_ff.yacc[2] == '0)
      |=> lane_data_o[2] == W_ZEROS;
  endproperty
  a_hpf_dc: assert property (p_hpf_dc) else $error("filter passed a constant input");

  property p_bypass;
    @(posedge clk_sys_i) disable iff (!rst_sync_ff)
      sample_valid_i && !hp_on && !pat_on
      |=> lane_valid_o && (lane_data_o[2] == $past(sample_i[2]));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered channel 3");

endmodule : apd_postproc
`default_nettype wire

// ### verification/apd_lane_rx.sv
// Lane receiver model: the far-side capture logic that takes each lane word.
// Assumes lane words come with a one-cycle valid on the sample clock.
`timescale 1ns/1ns
`default_nettype none
module apd_lane_rx
  import apd_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       lane_valid_i,
  input  wire apd_lanes_t lane_data_i,
  output var apd_lanes_t  word_o,
  output var int unsigned count_o
);
  initial count_o = 0;
  initial word_o = '0;

  // Capture only on valid, so a valid held too long shows up as extra words
  always @(posedge clk_sys_i) begin
    if (lane_valid_i) begin
      word_o  <= lane_data_i;
      count_o <= count_o + 1;
    end
  end
endmodule : apd_lane_rx
`default_nettype wire

// ### verification/testbench.sv
// Testbench: registers over AXI4-Lite, lane patterns, PRBS, high-pass
// filter and channel 4 gain and offset. Assumes the lane receiver model.
`timescale 1ns/1ns
`default_nettype none
module testbench
  import apd_pkg::*;
;
  localparam logic [13:0] CUST = 14'h0abc;
  localparam apd_lanes_t  IN   = {14'h002c, 14'h0021, 14'h0016, 14'h000b};
  logic         clk_sys_i;
  logic         rst_n_i;
  apd_axi_req_t req;
  apd_axi_rsp_t rsp;
  logic         sv;
  apd_lanes_t   si;
  logic         lv;
  apd_lanes_t   ld;
  apd_lanes_t   w;
  apd_lanes_t   w0;
  int unsigned  cnt;
  int           num_errors = 0;
  int           comparisons = 0;
  int           nsmp = 0;
  int           ys[2];

  apd_postproc #(.CUSTOM_PATTERN(CUST)) i_dut (
    .clk_sys_i     (clk_sys_i),
    .rst_n_i       (rst_n_i),
    .s_axi_i       (req),
    .s_axi_o       (rsp),
    .sample_valid_i(sv),
    .sample_i      (si),
    .lane_valid_o  (lv),
    .lane_data_o   (ld)
  );

  apd_lane_rx i_rx (
    .clk_sys_i   (clk_sys_i),
    .lane_valid_i(lv),
    .lane_data_i (ld),
    .word_o      (w),
    .count_o     (cnt)
  );

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Ready is looked at mid-cycle, where it is settled, and acted on at the next edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ad, wd, ar, wy, bv;
    logic [1:0] r;
    ad = 0;
    wd = 0;
    bv = 0;
    @(posedge clk_sys_i);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {16'h0000, d};
    req.wstrb   <= 4'h3;
    req.bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clk_sys_i);
      ar = rsp.awready;
      wy = rsp.wready;
      @(posedge clk_sys_i);
      if (ar) req.awvalid <= 1'b0;
      if (wy) req.wvalid <= 1'b0;
      ad = ad | ar;
      wd = wd | wy;
    end
    while (!bv) begin
      @(negedge clk_sys_i);
      bv = rsp.bvalid;
      r  = rsp.bresp;
      @(posedge clk_sys_i);
    end
    req.bready <= 1'b0;
    chk("write response", er, r);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, rv;
    logic [31:0] d;
    logic [1:0] r;
    rv = 0;
    @(posedge clk_sys_i);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    while (!rv) begin
      @(negedge clk_sys_i);
      ar = rsp.arready;
      rv = rsp.rvalid;
      d  = rsp.rdata;
      r  = rsp.rresp;
      @(posedge clk_sys_i);
      if (ar) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
    chk("read data", ed, d);
    chk("read response", er, r);
  endtask : rchk

  // One sample in; the receiver holds the lane word by the following negedge
  task automatic smp(input apd_lanes_t x);
    @(posedge clk_sys_i);
    sv <= 1'b1;
    si <= x;
    @(posedge clk_sys_i);
    sv <= 1'b0;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    nsmp++;
  endtask : smp

  task automatic close_out;
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // The run needs about 450 cycles, so this only fires on a hang
  initial begin
    repeat (8000) @(posedge clk_sys_i);
    num_errors++;
    close_out();
  end

  initial begin
    logic [7:0]  ad [5];
    logic [15:0] vl [5];
    ad = '{8'h0c, 8'h10, 8'h4c, 8'h50, 8'h54};
    vl = '{16'h1100, 16'h0100, 16'hfbff, 16'h03ff, 16'hfff5};
    rst_n_i = 1'b0;
    req = '0;
    sv = 1'b0;
    si = '0;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    for (int i = 0; i < 5; i++) rchk(ad[i], 32'h0, RESP_OKAY);
    rchk(8'h00, 32'h0, RESP_SLVERR);
    wr(8'h00, 16'hffff, RESP_SLVERR);
    for (int i = 0; i < 5; i++) wr(ad[i], vl[i], RESP_OKAY);
    for (int i = 0; i < 5; i++) rchk(ad[i], {16'h0, vl[i]}, RESP_OKAY);
    for (int i = 0; i < 5; i++) wr(ad[i], 16'h0000, RESP_OKAY);
    smp(IN);
    chk("bypass lanes", IN, w);
    // Every pattern code on lanes 1 and 2; lanes 3 and 4 stay normal
    wr(8'h10, 16'h0100, RESP_OKAY);
    for (int c = 0; c < 8; c++) begin
      wr(8'h54, {4'h0, 3'(c), 3'(c), 6'h00}, RESP_OKAY);
      smp(IN);
      w0 = w;
      smp(IN);
      chk("lanes 3 and 4", IN[3:2], w[3:2]);
      case (c)
        0: chk("normal", IN[1:0], w[1:0]);
        1: chk("sync", {2{W_SYNC}}, w[1:0]);
        2: chk("alternate", {2{W_ALT}}, w[1:0]);
        3: chk("custom", {2{CUST}}, w[1:0]);
        4: chk("ones", {2{W_ONES}}, w[1:0]);
        5: chk("toggle", w0[1:0] ^ {2{W_ONES}}, w[1:0]);
        6: chk("zeros", {2{W_ZEROS}}, w[1:0]);
        default: chk("ramp", {w0[1] + RAMP_STEP, w0[0] + RAMP_STEP}, w[1:0]);
      endcase
    end
    wr(8'h54, 16'hf000, RESP_OKAY);
    smp(IN);
    w0 = w;
    smp(IN);
    chk("prbs lanes alike", {4{w[0]}}, w);
    chk("prbs advances", 1, w !== w0);
    wr(8'h10, 16'h0000, RESP_OKAY);
    smp(IN);
    chk("prbs gated", IN, w);
    // Same history for truncate and round: bypass clears, zero sample, then a step
    for (int m = 0; m < 2; m++) begin
      wr(8'h54, 16'h0000, RESP_OKAY);
      smp('0);
      wr(8'h54, m ? 16'h0025 : 16'h0005, RESP_OKAY);
      // A repeated zero with a clear accumulator must give zero
      smp('0);
      chk("hpf quiet", '0, w);
      smp({4{14'd1000}});
      chk("hpf lanes alike", {4{w[0]}}, w);
      ys[m] = int'($signed(w[0]));
      chk("hpf step", 1, ys[m] > 750 && ys[m] < 850);
      repeat (30) smp({4{14'd1000}});
      chk("hpf decay", 1, $signed(w[0]) inside {[-4:4]});
    end
    chk("hpf round", 1, (ys[1] - ys[0]) inside {0, 1});
    wr(8'h54, 16'h0000, RESP_OKAY);
    wr(8'h0c, 16'h0100, RESP_OKAY);
    wr(8'h4c, 16'hf3ff, RESP_OKAY);
    wr(8'h50, 16'h03ff, RESP_OKAY);
    smp({14'd1000, IN[2:0]});
    chk("offset only", {14'd999, IN[2:0]}, w);
    smp({14'h0000, IN[2:0]});
    chk("offset of zero", {14'h3fff, IN[2:0]}, w);
    wr(8'h0c, 16'h1000, RESP_OKAY);
    smp({14'h03e8, IN[2:0]});
    chk("gain only", {14'h07cb, IN[2:0]}, w);
    wr(8'h0c, 16'h1100, RESP_OKAY);
    smp({14'd1000, IN[2:0]});
    // 6 dB is a factor 1.9953, so 1000 becomes 1995 before the offset
    chk("gain then offset", {14'd1994, IN[2:0]}, w);
    chk("lane word count", nsmp, cnt);
    close_out();
  end
endmodule : testbench
`default_nettype wire
